// ### design/sdcro_pkg.sv
package sdcro_pkg;
	// Mode register bit selecting the power-down exit type
	localparam int SDCRO_MR_SLOW_BIT = 12;
	// Nominal termination field position in the extended mode register
	localparam int SDCRO_EMR_RTT_HI = 6;
	localparam int SDCRO_EMR_RTT_LO = 2;
	localparam int SDCRO_EMR_ODT_EN_BIT = 2;
	localparam int SDCRO_MA_BANK_SEL = 0;
	localparam int SDCRO_EMR_BANK_SEL = 1;
	// Clock and timing figures
	localparam int SDCRO_CLK_PERIOD_PS = 25000;
	localparam int SDCRO_TMOD_PS = 12000;
	localparam int SDCRO_TMOD_CYC = (SDCRO_TMOD_PS + SDCRO_CLK_PERIOD_PS - 1)
		/ SDCRO_CLK_PERIOD_PS;
	localparam int SDCRO_TANPD_CYC = 3;
	localparam int SDCRO_TAXPD_CYC = 8;
	localparam int SDCRO_TAOND_CYC = 2;
	localparam int SDCRO_TAOFD_CYC = 2;
	localparam int SDCRO_TAONPD_CYC = 1;
	localparam int SDCRO_TAOFPD_CYC = 1;
	localparam int SDCRO_TDELAY_CYC = 2;
	localparam int SDCRO_INIT_CYC = 16;
	localparam int SDCRO_CNT_W = 8;
	localparam logic [1:0] SDCRO_RTT_RESET = 2'h0;

	typedef enum logic [2:0] {
		SDCRO_CMD_NOP,
		SDCRO_CMD_DESEL,
		SDCRO_CMD_LOAD_MODE,
		SDCRO_CMD_ACTIVATE,
		SDCRO_CMD_PRECHARGE,
		SDCRO_CMD_READ,
		SDCRO_CMD_WRITE,
		SDCRO_CMD_REFRESH
	} sdcro_cmd_t;

	typedef enum logic [1:0] {
		SDCRO_PWR_ACTIVE,
		SDCRO_PWR_FAST_PD,
		SDCRO_PWR_SLOW_PD,
		SDCRO_PWR_PRE_PD
	} sdcro_pwr_t;
endpackage

// ### design/sdcro_if.sv
`timescale 1ns/1ps
interface sdcro_if;
	logic ck_run;
	logic cke;
	logic odt;
	sdcro_pkg::sdcro_cmd_t cmd;
	logic [1:0] bank_sel;
	logic [15:0] addr;
	logic [7:0] dq;
	logic dq_valid;

	modport mem (
		input ck_run, cke, odt, cmd, bank_sel, addr,
		output dq, dq_valid
	);
	modport ctl (
		output ck_run, cke, odt, cmd, bank_sel, addr,
		input dq, dq_valid
	);
endinterface

// ### design/sdcro_mem.sv
`timescale 1ns/1ps
module sdcro_mem
	import sdcro_pkg::*;
#(
	parameter int BURST_LEN = 4
) (
	input wire logic clock,
	input wire logic sys_rst,
	sdcro_if.mem link,
	output logic odt_on,
	output logic odt_async,
	output logic [1:0] rtt_sel,
	output logic in_reset,
	output logic [1:0] pwr_state
);
	logic cke_s1_r, cke_s2_r, cke_prev_r;
	logic odt_s1_r, odt_s2_r, odt_prev_r;
	logic in_reset_r;
	logic mr_slow_r, odt_en_r;
	logic [1:0] rtt_r, rtt_pend_r;
	logic [SDCRO_CNT_W-1:0] mod_cnt_r, since_pd_r, odt_cnt_r;
	logic [SDCRO_CNT_W-1:0] burst_r;
	logic row_open_r, was_in_pd_r, pend_on_r, pend_valid_r;
	logic odt_on_r, odt_async_r;
	logic [7:0] dq_r;
	logic dq_valid_r;
	sdcro_pwr_t pwr_r;
	logic cke_fall, cke_rise, odt_edge, sync_timing;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cke_s1_r <= 1'b0;
			cke_s2_r <= 1'b0;
			cke_prev_r <= 1'b0;
			odt_s1_r <= 1'b0;
			odt_s2_r <= 1'b0;
			odt_prev_r <= 1'b0;
		end else begin
			cke_s1_r <= link.cke;
			cke_s2_r <= cke_s1_r;
			cke_prev_r <= cke_s2_r;
			odt_s1_r <= link.odt;
			odt_s2_r <= odt_s1_r;
			odt_prev_r <= odt_s2_r;
		end
	end

	assign cke_fall = cke_prev_r && !cke_s2_r;
	assign cke_rise = !cke_prev_r && cke_s2_r;
	assign odt_edge = odt_prev_r != odt_s2_r;

	// ----------------------------------------------------------------
	// Reset state and mode registers
	// ----------------------------------------------------------------
	// CKE dropped mid-burst, or clocks stopped with CKE low, is a reset;
	// a power-down here always keeps the clocks running.
	// CKE, ck_run and burst_r all matter
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			in_reset_r <= 1'b1;
		end else if ((cke_fall && burst_r != '0)
			|| (!link.ck_run && !cke_s2_r)) begin
			in_reset_r <= 1'b1;
		end else if (in_reset_r && cke_s2_r && link.cmd == SDCRO_CMD_LOAD_MODE
			&& link.bank_sel == 2'(SDCRO_MA_BANK_SEL)) begin
			in_reset_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mr_slow_r <= 1'b0;
			odt_en_r <= 1'b0;
			rtt_pend_r <= SDCRO_RTT_RESET;
		end else if (cke_s2_r && link.cmd == SDCRO_CMD_LOAD_MODE) begin
			if (link.bank_sel == 2'(SDCRO_MA_BANK_SEL)) begin
				mr_slow_r <= link.addr[SDCRO_MR_SLOW_BIT];
			end else if (link.bank_sel == 2'(SDCRO_EMR_BANK_SEL)
				&& !in_reset_r) begin
				rtt_pend_r <= {link.addr[SDCRO_EMR_RTT_HI],
					link.addr[SDCRO_EMR_RTT_LO]};
				odt_en_r <= (link.addr[SDCRO_EMR_RTT_HI] ||
					link.addr[SDCRO_EMR_RTT_LO]);
			end
		end else if (in_reset_r) begin
			odt_en_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mod_cnt_r <= '0;
			rtt_r <= SDCRO_RTT_RESET;
		end else if (cke_s2_r && link.cmd == SDCRO_CMD_LOAD_MODE
			&& link.bank_sel == 2'(SDCRO_EMR_BANK_SEL) && !in_reset_r) begin
			mod_cnt_r <= SDCRO_CNT_W'(SDCRO_TMOD_CYC);
		end else if (mod_cnt_r != '0) begin
			mod_cnt_r <= mod_cnt_r - 1'b1;
			if (mod_cnt_r == SDCRO_CNT_W'(1)) begin
				rtt_r <= rtt_pend_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power state tracking
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			row_open_r <= 1'b0;
		end else if (in_reset_r) begin
			row_open_r <= 1'b0;
		end else if (cke_s2_r && link.cmd == SDCRO_CMD_ACTIVATE) begin
			row_open_r <= 1'b1;
		end else if (cke_s2_r && link.cmd == SDCRO_CMD_PRECHARGE) begin
			row_open_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_r <= SDCRO_PWR_ACTIVE;
			since_pd_r <= '0;
			was_in_pd_r <= 1'b0;
		end else begin
			if (cke_fall || cke_rise) begin
				since_pd_r <= '0;
			end else if (since_pd_r != '1) begin
				since_pd_r <= since_pd_r + 1'b1;
			end
			if (cke_fall) begin
				if (!row_open_r) begin
					pwr_r <= SDCRO_PWR_PRE_PD;
				end else if (mr_slow_r) begin
					pwr_r <= SDCRO_PWR_SLOW_PD;
				end else begin
					pwr_r <= SDCRO_PWR_FAST_PD;
				end
			end else if (cke_rise) begin
				was_in_pd_r <= (pwr_r != SDCRO_PWR_FAST_PD);
				pwr_r <= SDCRO_PWR_ACTIVE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Termination timing category
	// ----------------------------------------------------------------
	always_comb begin
		sync_timing = 1'b1;
		if (pwr_r == SDCRO_PWR_SLOW_PD || pwr_r == SDCRO_PWR_PRE_PD) begin
			sync_timing = 1'b0;
			if (since_pd_r == '0) begin
				sync_timing = 1'b0;
			end
		end else if (cke_s2_r && was_in_pd_r &&
			since_pd_r < SDCRO_CNT_W'(SDCRO_TAXPD_CYC)) begin
			sync_timing = 1'b0;
		end else if (!cke_s2_r && pwr_r == SDCRO_PWR_FAST_PD) begin
			sync_timing = 1'b1;
		end
	end

	// Edges that land within tANPD before CKE falls are re-timed as async
	// once the entry is seen, since the future cannot be known here.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			odt_cnt_r <= '0;
			pend_on_r <= 1'b0;
			pend_valid_r <= 1'b0;
			odt_on_r <= 1'b0;
			odt_async_r <= 1'b0;
		end else if (in_reset_r || !odt_en_r || mod_cnt_r != '0) begin
			odt_cnt_r <= '0;
			pend_valid_r <= 1'b0;
			odt_on_r <= 1'b0;
			odt_async_r <= 1'b0;
		end else if (odt_edge) begin
			pend_on_r <= odt_s2_r;
			pend_valid_r <= 1'b1;
			odt_async_r <= !sync_timing;
			if (sync_timing) begin
				odt_cnt_r <= SDCRO_CNT_W'(odt_s2_r ? SDCRO_TAOND_CYC
					: SDCRO_TAOFD_CYC);
			end else begin
				odt_cnt_r <= SDCRO_CNT_W'(odt_s2_r ? SDCRO_TAONPD_CYC
					: SDCRO_TAOFPD_CYC);
			end
		end else if (pend_valid_r) begin
			if (cke_fall && odt_cnt_r != '0
				&& SDCRO_CNT_W'(SDCRO_TANPD_CYC) > odt_cnt_r) begin
				odt_async_r <= 1'b1;
			end
			if (odt_cnt_r <= SDCRO_CNT_W'(1)) begin
				odt_on_r <= pend_on_r;
				pend_valid_r <= 1'b0;
				odt_cnt_r <= '0;
			end else begin
				odt_cnt_r <= odt_cnt_r - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read burst model
	// ----------------------------------------------------------------
	// burst may finish late
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			burst_r <= '0;
			dq_r <= 8'h00;
			dq_valid_r <= 1'b0;
		end else if (cke_s2_r && !in_reset_r
			&& link.cmd == SDCRO_CMD_READ) begin
			burst_r <= SDCRO_CNT_W'(BURST_LEN);
			dq_r <= link.addr[7:0];
			dq_valid_r <= 1'b0;
		end else if (burst_r != '0 && cke_s2_r) begin
			burst_r <= burst_r - 1'b1;
			dq_r <= dq_r + 8'h01;
			dq_valid_r <= 1'b1;
		end else begin
			dq_valid_r <= 1'b0;
		end
	end

	assign link.dq = dq_r;
	assign link.dq_valid = dq_valid_r;
	assign odt_on = odt_on_r;
	assign odt_async = odt_async_r;
	assign rtt_sel = rtt_r;
	assign in_reset = in_reset_r;
	assign pwr_state = pwr_r;
endmodule

// ### design/sdcro_ctl.sv
`timescale 1ns/1ps
module sdcro_ctl
	import sdcro_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	sdcro_if.ctl link,
	input wire logic reset_req,
	input wire logic rtt_req,
	input wire logic [1:0] rtt_val,
	input wire logic odt_req,
	output logic busy,
	output logic ready
);
	typedef enum logic [2:0] {
		SDCRO_C_RUN, SDCRO_C_DELAY, SDCRO_C_HALT, SDCRO_C_CLKUP,
		SDCRO_C_INIT, SDCRO_C_ODTOFF, SDCRO_C_MODWAIT
	} sdcro_cst_t;
	sdcro_cst_t st_r;
	logic [SDCRO_CNT_W-1:0] cnt_r;
	logic cke_r, ck_run_r, odt_r, ready_r, busy_r;
	sdcro_cmd_t cmd_r;
	logic [1:0] bank_r;
	logic [15:0] addr_r;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= SDCRO_C_HALT;
			cnt_r <= '0;
			cke_r <= 1'b0;
			ck_run_r <= 1'b0;
			odt_r <= 1'b0;
			ready_r <= 1'b0;
			busy_r <= 1'b1;
			cmd_r <= SDCRO_CMD_NOP;
			bank_r <= 2'h0;
			addr_r <= 16'h0000;
		end else begin
			cmd_r <= SDCRO_CMD_NOP;
			case (st_r)
			SDCRO_C_RUN: begin
				odt_r <= odt_req;
				if (reset_req) begin
					cke_r <= 1'b0;
					odt_r <= 1'b0;
					ready_r <= 1'b0;
					busy_r <= 1'b1;
					cnt_r <= SDCRO_CNT_W'(SDCRO_TDELAY_CYC);
					st_r <= SDCRO_C_DELAY;
				end else if (rtt_req) begin
					odt_r <= 1'b0;
					cnt_r <= SDCRO_CNT_W'(SDCRO_TAOFD_CYC);
					st_r <= SDCRO_C_ODTOFF;
				end
			end
			SDCRO_C_DELAY: begin
				if (cnt_r == '0) begin
					ck_run_r <= 1'b0;
					st_r <= SDCRO_C_HALT;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
			SDCRO_C_HALT: begin
				ck_run_r <= 1'b1;
				cnt_r <= SDCRO_CNT_W'(SDCRO_INIT_CYC);
				st_r <= SDCRO_C_CLKUP;
			end
			SDCRO_C_CLKUP: begin
				if (cnt_r == '0) begin
					cke_r <= 1'b1;
					cnt_r <= SDCRO_CNT_W'(SDCRO_INIT_CYC);
					st_r <= SDCRO_C_INIT;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
			SDCRO_C_INIT: begin
				if (cnt_r == '0) begin
					cmd_r <= SDCRO_CMD_LOAD_MODE;
					bank_r <= 2'(SDCRO_MA_BANK_SEL);
					addr_r <= 16'h0000;
					ready_r <= 1'b1;
					busy_r <= 1'b0;
					st_r <= SDCRO_C_RUN;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
			SDCRO_C_ODTOFF: begin
				if (cnt_r == '0) begin
					cmd_r <= SDCRO_CMD_LOAD_MODE;
					bank_r <= 2'(SDCRO_EMR_BANK_SEL);
					addr_r <= 16'h0000;
					addr_r[SDCRO_EMR_RTT_HI] <= rtt_val[1];
					addr_r[SDCRO_EMR_RTT_LO] <= rtt_val[0];
					cnt_r <= SDCRO_CNT_W'(SDCRO_TMOD_CYC + 1);
					st_r <= SDCRO_C_MODWAIT;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
			SDCRO_C_MODWAIT: begin
				odt_r <= 1'b0;
				if (cnt_r == '0) begin
					st_r <= SDCRO_C_RUN;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
			default: st_r <= SDCRO_C_HALT;
			endcase
		end
	end

	assign link.cke = cke_r;
	assign link.ck_run = ck_run_r;
	assign link.odt = odt_r;
	assign link.cmd = cmd_r;
	assign link.bank_sel = bank_r;
	assign link.addr = addr_r;
	assign busy = busy_r;
	assign ready = ready_r;
endmodule

// ### verif/sdcro_asserts.sv
`timescale 1ns/1ps
module sdcro_asserts
	import sdcro_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ck_run,
	input wire logic cke,
	input wire logic odt,
	input wire sdcro_cmd_t cmd,
	input wire logic [1:0] bank_sel
);
	logic emr_load;
	logic quiet;

	assign emr_load = (cmd == SDCRO_CMD_LOAD_MODE) &&
		(bank_sel == 2'(SDCRO_EMR_BANK_SEL));
	assign quiet = (cmd == SDCRO_CMD_NOP) || (cmd == SDCRO_CMD_DESEL);

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	// ----------------
	// Controller side
	// ----------------
	chk_clk_before_cke:
		assert property ($rose(cke) |-> ck_run && $past(ck_run))
		else $error("cke raised without running clocks");
	chk_clk_while_cke:
		assert property (cke |-> ck_run)
		else $error("clocks stopped while cke high");
	chk_init_quiet:
		assert property ($rose(cke) |-> quiet [*8])
		else $error("command issued too soon after cke rise");
	chk_tdelay_wait:
		assert property ($fell(ck_run) |-> !cke && $past(!cke) &&
			$past(!cke, 2))
		else $error("clocks stopped before tdelay");
	chk_reset_cmds:
		assert property (!cke |-> quiet)
		else $error("non idle command while cke low");
	chk_aofd_before_load:
		assert property (emr_load |-> $past(!odt) && $past(!odt, 2))
		else $error("termination load before turn-off delay");
	chk_odt_low_tmod:
		assert property (emr_load |-> !odt [*2])
		else $error("odt raised inside tmod window");
	chk_odt_after_enable:
		assert property ($rose(odt) |-> !$past(emr_load) &&
			!$past(emr_load, 2))
		else $error("odt used right after termination enable");

	cover property ($fell(ck_run));
	cover property (emr_load);
	cover property ($rose(odt));
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
	import sdcro_pkg::*;
	logic clock;
	logic sys_rst;
	logic reset_req;
	logic rtt_req;
	logic [1:0] rtt_val;
	logic odt_req;
	logic busy;
	logic ready;
	logic odt_on;
	logic odt_async;
	logic [1:0] rtt_sel;
	logic in_reset;
	logic [1:0] pwr_state;
	int mismatches;
	int cmp_count;

	sdcro_if u_sdcro_if();
	sdcro_mem u_sdcro_mem (.clock(clock), .sys_rst(sys_rst),
		.link(u_sdcro_if), .odt_on(odt_on), .odt_async(odt_async),
		.rtt_sel(rtt_sel), .in_reset(in_reset), .pwr_state(pwr_state));
	sdcro_ctl u_sdcro_ctl (.clock(clock), .sys_rst(sys_rst),
		.link(u_sdcro_if), .reset_req(reset_req), .rtt_req(rtt_req),
		.rtt_val(rtt_val), .odt_req(odt_req), .busy(busy), .ready(ready));
	sdcro_asserts u_sdcro_asserts (.clock(clock), .sys_rst(sys_rst),
		.ck_run(u_sdcro_if.ck_run), .cke(u_sdcro_if.cke),
		.odt(u_sdcro_if.odt), .cmd(u_sdcro_if.cmd),
		.bank_sel(u_sdcro_if.bank_sel));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ----------------
	// Helpers
	// ----------------
	function automatic logic [1:0] pick(input int sel);
		case (sel)
			0: pick = {1'b0, odt_on};
			1: pick = rtt_sel;
			2: pick = {1'b0, in_reset};
			3: pick = pwr_state;
			4: pick = {1'b0, odt_async};
			5: pick = {1'b0, busy};
			default: pick = {1'b0, ready};
		endcase
	endfunction

	// Waits a bounded number of cycles for a value, then compares it
	task automatic expect_sig(input string name, input int sel,
		input logic [1:0] exp, input int wait_n);
		for (int i = 0; i < wait_n && pick(sel) !== exp; i++) begin
			@(posedge clock);
			#2;
		end
		cmp_count++;
		if (pick(sel) !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, pick(sel));
		end
	endtask

	task automatic step();
		@(posedge clock);
		#2;
	endtask

	task automatic set_rtt(input logic [1:0] v);
		step();
		rtt_val = v;
		rtt_req = 1'b1;
		step();
		rtt_req = 1'b0;
		step();
		expect_sig("ready", 6, 2'h1, 40);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		complete_run();
	end

	// ----------------
	// Scenarios
	// ----------------
	initial begin
		mismatches = 0;
		cmp_count = 0;
		sys_rst = 1'b1;
		reset_req = 1'b0;
		rtt_req = 1'b0;
		rtt_val = 2'h0;
		odt_req = 1'b0;
		repeat (8) @(posedge clock);
		#2;
		sys_rst = 1'b0;
		expect_sig("in_reset", 2, 2'h1, 0);
		expect_sig("odt_on", 0, 2'h0, 0);
		expect_sig("ready", 6, 2'h1, 200);
		expect_sig("in_reset", 2, 2'h0, 5);
		expect_sig("pwr_state", 3, SDCRO_PWR_ACTIVE, 0);
		for (int v = 3; v >= 0; v--) begin
			set_rtt(2'(v));
			expect_sig("rtt_sel", 1, 2'(v), 20);
		end
		// Termination disabled: a request must not reach the pin
		odt_req = 1'b1;
		repeat (10) step();
		expect_sig("odt_on", 0, 2'h0, 0);
		odt_req = 1'b0;
		set_rtt(2'h1);
		odt_req = 1'b1;
		expect_sig("odt_on", 0, 2'h1, 20);
		expect_sig("odt_async", 4, 2'h0, 0);
		odt_req = 1'b0;
		expect_sig("odt_on", 0, 2'h0, 20);
		expect_sig("odt_async", 4, 2'h0, 0);
		// Value change while terminated: pin must drop, then come back
		odt_req = 1'b1;
		expect_sig("odt_on", 0, 2'h1, 20);
		set_rtt(2'h3);
		expect_sig("odt_on", 0, 2'h0, 20);
		expect_sig("rtt_sel", 1, 2'h3, 20);
		expect_sig("odt_on", 0, 2'h1, 20);
		// Reset through cke while odt is still requested
		step();
		reset_req = 1'b1;
		step();
		reset_req = 1'b0;
		expect_sig("busy", 5, 2'h1, 10);
		expect_sig("in_reset", 2, 2'h1, 20);
		expect_sig("odt_on", 0, 2'h0, 20);
		expect_sig("ready", 6, 2'h1, 300);
		expect_sig("in_reset", 2, 2'h0, 5);
		set_rtt(2'h2);
		expect_sig("rtt_sel", 1, 2'h2, 20);
		expect_sig("odt_on", 0, 2'h1, 20);
		complete_run();
	end
endmodule
